/* File: hw/peripheral_interrupt_flags.sv */
// Peripheral interrupt enable and request registers with bus slave
//
// Overview of operation
// - Enable bit 6 gates oscillator generator interrupt
// - Enable bit 5 gates waveform shutdown interrupt
// - Enable bit 4 gates zero-cross interrupt
// - Enable bits 3..0 gate logic cells 4..1
// - Peripheral and core requests need peripheral enable set; irq does not
// - Flags set regardless of enables
// - Serial receive/transmit flags read-only, reset zero
// - First request register writable flag layout
// - Second request register flag layout
// - Third request register mirrors third enable
// - Unimplemented bits ignore writes, read zero
// - Flag one means pending, zero not
// - All bits clear to zero on reset
`timescale 1ns/10ps
`default_nettype none
module peripheral_interrupt_flags (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [irq_flags_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [irq_flags_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [irq_flags_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Sources of the first request register
  input wire logic t1_gate_evt,
  input wire logic converter_evt,
  input wire logic serial_rx_level,
  input wire logic serial_tx_level,
  input wire logic sync_serial_evt,
  input wire logic capture1_evt,
  input wire logic t2_match_evt,
  input wire logic t1_overflow_evt,
  // Sources of the second request register
  input wire logic osc_fail_evt,
  input wire logic comparator2_evt,
  input wire logic comparator1_evt,
  input wire logic bus_collision_evt,
  input wire logic t6_match_evt,
  input wire logic t4_match_evt,
  input wire logic capture2_evt,
  // Sources of the third request register
  input wire logic osc_gen_evt,
  input wire logic shutdown_evt,
  input wire logic zero_cross_evt,
  input wire logic [3:0] logic_cell_evt,
  // Requests toward the core and the system
  output logic periph_irq_req,
  output logic core_irq_req,
  output logic irq
);

  // Bus request bundle and handshake
  irq_flags_pkg::avmm_req_t bus_req;
  logic capture;
  logic wr_commit;
  logic wr_ok;
  logic [7:0] wr_byte;

  // Software-owned registers
  logic [7:0] enable_1_reg;
  logic [7:0] enable_2_reg;
  logic [7:0] enable_3_reg;
  logic [7:0] core_ctrl_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_mask_reg;
  logic [7:0] irq_status_next;
  logic [irq_flags_pkg::DATA_W-1:0] readdata_reg;
  logic [7:0] rd_value;

  // Request flag banks
  logic [7:0] request_1;
  logic [7:0] request_2;
  logic [7:0] request_3;
  logic [7:0] evt_1;
  logic [7:0] evt_2;
  logic [7:0] evt_3;
  logic [7:0] ro_1;
  logic new_1;
  logic new_2;
  logic new_3;

  // Named enable and flag fields
  logic osc_gen_irq_en;
  logic shutdown_irq_en;
  logic zero_cross_irq_en;
  logic logic_cell4_irq_en;
  logic logic_cell3_irq_en;
  logic logic_cell2_irq_en;
  logic logic_cell1_irq_en;
  logic global_irq_en;
  logic periph_global_en;
  logic serial_rx_flag;
  logic serial_tx_flag;
  logic [7:0] enables_3;
  logic [7:0] pending_1;
  logic [7:0] pending_2;
  logic [7:0] pending_3;
  logic [7:0] pending_sum;

  // Write strobes per register
  logic wr_en1;
  logic wr_en2;
  logic wr_en3;
  logic wr_rq1;
  logic wr_rq2;
  logic wr_rq3;
  logic wr_core;
  logic wr_stat;
  logic wr_mask;

  // Bundle the bus signals for the handshake module
  assign bus_req = '{address: avs_address, read: avs_read,
                     write: avs_write, writedata: avs_writedata,
                     byteenable: avs_byteenable};

  avmm_wait_slave u_slave (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .req(bus_req),
    .waitrequest(avs_waitrequest),
    .capture(capture),
    .wr_commit(wr_commit)
  );

  // Only the low byte lane carries register data
  assign wr_ok = wr_commit & bus_req.byteenable[0];
  assign wr_byte = bus_req.writedata[7:0];

  // Address decode for writes; unmapped addresses are ignored
  assign wr_en1 = wr_ok & (bus_req.address == irq_flags_pkg::OFS_ENABLE_1);
  assign wr_en2 = wr_ok & (bus_req.address == irq_flags_pkg::OFS_ENABLE_2);
  assign wr_en3 = wr_ok & (bus_req.address == irq_flags_pkg::OFS_ENABLE_3);
  assign wr_rq1 = wr_ok & (bus_req.address == irq_flags_pkg::OFS_REQUEST_1);
  assign wr_rq2 = wr_ok & (bus_req.address == irq_flags_pkg::OFS_REQUEST_2);
  assign wr_rq3 = wr_ok & (bus_req.address == irq_flags_pkg::OFS_REQUEST_3);
  assign wr_core = wr_ok & (bus_req.address == irq_flags_pkg::OFS_CORE_CTRL);
  assign wr_stat = wr_ok & (bus_req.address == irq_flags_pkg::OFS_IRQ_STATUS);
  assign wr_mask = wr_ok & (bus_req.address == irq_flags_pkg::OFS_IRQ_MASK);

  // Enable registers; unimplemented bits never store
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      enable_1_reg <= irq_flags_pkg::REG_RESET;
      enable_2_reg <= irq_flags_pkg::REG_RESET;
      enable_3_reg <= irq_flags_pkg::REG_RESET;
    end else begin
      if (wr_en1) begin
        enable_1_reg <= wr_byte & irq_flags_pkg::IMPL_ENABLE_1;
      end
      if (wr_en2) begin
        enable_2_reg <= wr_byte & irq_flags_pkg::IMPL_ENABLE_2;
      end
      // Top bit of the third enable register is never stored
      if (wr_en3) begin
        enable_3_reg <= wr_byte & irq_flags_pkg::IMPL_ENABLE_3;
      end
    end
  end

  // Core interrupt control: global and peripheral enables
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      core_ctrl_reg <= irq_flags_pkg::REG_RESET;
    end else if (wr_core) begin
      core_ctrl_reg <= wr_byte & irq_flags_pkg::IMPL_CORE_CTRL;
    end
  end

  // Enable fields of the third enable register
  assign osc_gen_irq_en = enable_3_reg[6];
  assign shutdown_irq_en = enable_3_reg[5];
  assign zero_cross_irq_en = enable_3_reg[4];
  assign logic_cell4_irq_en = enable_3_reg[3];
  assign logic_cell3_irq_en = enable_3_reg[2];
  assign logic_cell2_irq_en = enable_3_reg[1];
  assign logic_cell1_irq_en = enable_3_reg[0];
  // Global and peripheral enables of the core control register
  assign global_irq_en = core_ctrl_reg[irq_flags_pkg::GLOBAL_EN_BIT];
  assign periph_global_en = core_ctrl_reg[irq_flags_pkg::PERIPH_EN_BIT];

  // Event vectors in register bit order, bit 7 first
  assign evt_1 = {t1_gate_evt, converter_evt, 2'b00, sync_serial_evt,
                  capture1_evt, t2_match_evt, t1_overflow_evt};
  assign evt_2 = {osc_fail_evt, comparator2_evt, comparator1_evt, 1'b0,
                  bus_collision_evt, t6_match_evt, t4_match_evt,
                  capture2_evt};
  // Top bit of the third bank has no source
  assign evt_3 = {1'b0, osc_gen_evt, shutdown_evt, zero_cross_evt,
                  logic_cell_evt};

  // Serial flags follow the serial port's own levels
  always_comb begin
    ro_1 = 8'h00;
    ro_1[irq_flags_pkg::RX_BIT] = serial_rx_level;
    ro_1[irq_flags_pkg::TX_BIT] = serial_tx_level;
  end

  // First request register with two read-only flags
  irq_flag_bank #(
    .IMPL(irq_flags_pkg::IMPL_REQUEST_1),
    .RO(irq_flags_pkg::RO_REQUEST_1)
  ) u_request_1 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wr_en(wr_rq1),
    .wr_data(wr_byte),
    .set_evt(evt_1),
    .ro_level(ro_1),
    .flags_reg(request_1),
    .new_set(new_1)
  );

  // Second request register
  irq_flag_bank #(
    .IMPL(irq_flags_pkg::IMPL_REQUEST_2),
    .RO(irq_flags_pkg::RO_NONE)
  ) u_request_2 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wr_en(wr_rq2),
    .wr_data(wr_byte),
    .set_evt(evt_2),
    .ro_level(8'h00),
    .flags_reg(request_2),
    .new_set(new_2)
  );

  // Third request register
  irq_flag_bank #(
    .IMPL(irq_flags_pkg::IMPL_REQUEST_3),
    .RO(irq_flags_pkg::RO_NONE)
  ) u_request_3 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wr_en(wr_rq3),
    .wr_data(wr_byte),
    .set_evt(evt_3),
    .ro_level(8'h00),
    .flags_reg(request_3),
    .new_set(new_3)
  );

  // Serial flags picked out for the pending logic
  assign serial_rx_flag = request_1[irq_flags_pkg::RX_BIT];
  assign serial_tx_flag = request_1[irq_flags_pkg::TX_BIT];

  // Pending where a flag meets its enable; a set flag means pending
  assign enables_3 = {1'b0, osc_gen_irq_en, shutdown_irq_en,
                      zero_cross_irq_en, logic_cell4_irq_en,
                      logic_cell3_irq_en, logic_cell2_irq_en,
                      logic_cell1_irq_en};
  always_comb begin
    pending_1 = request_1 & enable_1_reg;
    pending_1[irq_flags_pkg::RX_BIT] =
      serial_rx_flag & enable_1_reg[irq_flags_pkg::RX_BIT];
    pending_1[irq_flags_pkg::TX_BIT] =
      serial_tx_flag & enable_1_reg[irq_flags_pkg::TX_BIT];
  end
  // Second and third banks meet their enables bit for bit
  assign pending_2 = request_2 & enable_2_reg;
  assign pending_3 = request_3 & enables_3;
  // Summary: one bit for each request register
  assign pending_sum = {5'b0_0000, |pending_3, |pending_2, |pending_1};

  // Peripheral request to the core, gated by the peripheral enable
  assign periph_irq_req = periph_global_en
                        & (|pending_sum);
  // The core also needs the global enable
  assign core_irq_req = global_irq_en & periph_irq_req;

  // Sticky status; a new flag wins over a write-one clear
  always_comb begin
    irq_status_next = irq_status_reg;
    // Write-one clear first, so events applied after it win
    if (wr_stat) begin
      irq_status_next = irq_status_reg & ~wr_byte;
    end
    irq_status_next[irq_flags_pkg::STAT_REQ1_BIT] =
      irq_status_next[irq_flags_pkg::STAT_REQ1_BIT] | new_1;
    irq_status_next[irq_flags_pkg::STAT_REQ2_BIT] =
      irq_status_next[irq_flags_pkg::STAT_REQ2_BIT] | new_2;
    irq_status_next[irq_flags_pkg::STAT_REQ3_BIT] =
      irq_status_next[irq_flags_pkg::STAT_REQ3_BIT] | new_3;
    // Keep only the three status bits
    irq_status_next = irq_status_next & irq_flags_pkg::IMPL_IRQ;
  end

  // Status and mask storage
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_status_reg <= irq_flags_pkg::REG_RESET;
      irq_mask_reg <= irq_flags_pkg::REG_RESET;
    end else begin
      irq_status_reg <= irq_status_next;
      if (wr_mask) begin
        irq_mask_reg <= wr_byte & irq_flags_pkg::IMPL_IRQ;
      end
    end
  end

  // System interrupt: level while any unmasked status bit is set
  assign irq = |(irq_status_reg & irq_mask_reg);

  // Read multiplexer; unmapped or unused bits read as zero
  always_comb begin
    unique case (bus_req.address)
      irq_flags_pkg::OFS_ENABLE_1: rd_value = enable_1_reg;
      irq_flags_pkg::OFS_ENABLE_2: rd_value = enable_2_reg;
      irq_flags_pkg::OFS_ENABLE_3: rd_value = enable_3_reg;
      irq_flags_pkg::OFS_REQUEST_1: rd_value = request_1;
      irq_flags_pkg::OFS_REQUEST_2: rd_value = request_2;
      irq_flags_pkg::OFS_REQUEST_3: rd_value = request_3;
      irq_flags_pkg::OFS_CORE_CTRL: rd_value = core_ctrl_reg;
      irq_flags_pkg::OFS_PENDING: rd_value = pending_sum;
      irq_flags_pkg::OFS_IRQ_STATUS: rd_value = irq_status_reg;
      irq_flags_pkg::OFS_IRQ_MASK: rd_value = irq_mask_reg;
      default: rd_value = 8'h00;
    endcase
  end

  // Read data captured in the wait cycle, held until the next read
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      readdata_reg <= 32'h0000_0000;
    end else if (capture && bus_req.read) begin
      readdata_reg <= {24'h00_0000, rd_value};
    end
  end

  // Upper lanes of read data are always zero
  assign avs_readdata = readdata_reg;

endmodule : peripheral_interrupt_flags
`default_nettype wire

/* File: hw/irq_flags_pkg.sv */
// Shared constants and types for the peripheral interrupt flag block
package irq_flags_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Byte offsets of the registers
  localparam logic [7:0] OFS_ENABLE_1 = 8'h00;
  localparam logic [7:0] OFS_ENABLE_2 = 8'h04;
  localparam logic [7:0] OFS_ENABLE_3 = 8'h08;
  localparam logic [7:0] OFS_REQUEST_1 = 8'h0C;
  localparam logic [7:0] OFS_REQUEST_2 = 8'h10;
  localparam logic [7:0] OFS_REQUEST_3 = 8'h14;
  localparam logic [7:0] OFS_CORE_CTRL = 8'h18;
  localparam logic [7:0] OFS_PENDING = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  // Value of every register after reset
  localparam logic [7:0] REG_RESET = 8'h00;

  // Implemented bits of each register
  localparam logic [7:0] IMPL_ENABLE_1 = 8'hFF;
  localparam logic [7:0] IMPL_ENABLE_2 = 8'hEF;
  localparam logic [7:0] IMPL_ENABLE_3 = 8'h7F;
  localparam logic [7:0] IMPL_REQUEST_1 = 8'hFF;
  localparam logic [7:0] IMPL_REQUEST_2 = 8'hEF;
  localparam logic [7:0] IMPL_REQUEST_3 = 8'h7F;
  localparam logic [7:0] IMPL_CORE_CTRL = 8'hC0;
  localparam logic [7:0] IMPL_IRQ = 8'h07;

  // Read-only flags of the first request register (receive, transmit)
  localparam logic [7:0] RO_REQUEST_1 = 8'h30;
  localparam logic [7:0] RO_NONE = 8'h00;
  localparam int RX_BIT = 5;
  localparam int TX_BIT = 4;

  // Core interrupt control bit positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;

  // Interrupt status bits: a flag newly set in request register 1..3
  localparam int STAT_REQ1_BIT = 0;
  localparam int STAT_REQ2_BIT = 1;
  localparam int STAT_REQ3_BIT = 2;

  // One Avalon-MM request as seen by the slave
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_t;

endpackage : irq_flags_pkg

/* File: hw/avmm_wait_slave.sv */
// Avalon-MM handshake: one wait cycle, then the access completes
`timescale 1ns/10ps
`default_nettype none
module avmm_wait_slave (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Request from the master
  input wire irq_flags_pkg::avmm_req_t req,
  // Handshake and strobes
  output logic waitrequest,
  output logic capture,
  output logic wr_commit
);

  logic ack_reg;
  logic ack_next;
  logic active;

  // Any access in progress
  assign active = req.read | req.write;
  // First cycle of an access: stall and let read data be captured
  assign ack_next = active & ~ack_reg;
  assign capture = ack_next;
  assign waitrequest = active & ~ack_reg;
  // Write takes effect on the edge where waitrequest is seen low
  assign wr_commit = req.write & ack_reg;

  // Acknowledge flag, high for the second cycle of each access
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end

endmodule : avmm_wait_slave
`default_nettype wire

/* File: hw/irq_flag_bank.sv */
// One eight-bit bank of interrupt request flags
`timescale 1ns/10ps
`default_nettype none
module irq_flag_bank #(
  parameter logic [7:0] IMPL = 8'hFF,
  parameter logic [7:0] RO = 8'h00
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Software write
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // Hardware sources
  input wire logic [7:0] set_evt,
  input wire logic [7:0] ro_level,
  // State
  output logic [7:0] flags_reg,
  output logic new_set
);

  logic [7:0] wmask;
  logic [7:0] flags_next;
  logic [7:0] held;

  assign wmask = IMPL & ~RO;
  // Software value, or the old one when no write
  assign held = wr_en ? wr_data : flags_reg;
  // Events OR in after the write so a set beats a clear
  assign flags_next = (held & wmask) | (set_evt & wmask)
                    | (ro_level & RO & IMPL);
  // Any flag going from clear to set
  assign new_set = |(flags_next & ~flags_reg);

  // Flag storage
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flags_reg <= irq_flags_pkg::REG_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

endmodule : irq_flag_bank
`default_nettype wire

/* File: tb/irq_flags_sva.sv */
// Property checker for the peripheral interrupt flag block
`timescale 1ns/10ps
`default_nettype none
module irq_flags_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [irq_flags_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Serial levels and requests
  input wire logic serial_rx_level,
  input wire logic serial_tx_level,
  input wire logic periph_irq_req,
  input wire logic core_irq_req,
  input wire logic irq
);
  // Reset seen high at the last edge; masks the release edge itself
  logic reset_done_reg;
  always_ff @(posedge sys_clk) begin
    reset_done_reg <= reset_n;
  end

  // One clock domain for all checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n || !reset_done_reg);

  // Access waits exactly one cycle
  property p_wait_first;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("bad wait");
  property p_wait_idle;
    avs_waitrequest |-> (avs_read || avs_write) ##1 !avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("idle wait");
  // Upper read lanes carry nothing
  property p_rd_upper;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper bits");
  // Read data moves only after a read
  property p_rd_hold;
    $changed(avs_readdata) |-> $past(avs_read);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
  // Requests quiet as reset ends
  property p_rst_quiet;
    $rose(reset_n) |-> !irq && !periph_irq_req && !core_irq_req;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("reset");
  // Core request needs the peripheral request
  property p_core_needs;
    core_irq_req |-> periph_irq_req;
  endproperty
  a_core_needs: assert property (p_core_needs) else $error("core");
  property p_core_rise;
    $rose(core_irq_req) |-> $past(avs_write) || $rose(periph_irq_req);
  endproperty
  a_core_rise: assert property (p_core_rise) else $error("rise");
  // Pending state drops only by software or a serial level
  property p_irq_fall;
    $fell(irq) |-> $past(avs_write);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq drop");
  property p_preq_fall;
    $fell(periph_irq_req) |-> $past(avs_write)
      || ($past(serial_rx_level, 2) && !$past(serial_rx_level))
      || ($past(serial_tx_level, 2) && !$past(serial_tx_level));
  endproperty
  a_preq_fall: assert property (p_preq_fall) else $error("drop");
endmodule : irq_flags_sva
`default_nettype wire

/* File: tb/periph_event_model.sv */
// Behavioural on-chip event sources facing the flag block
`timescale 1ns/10ps
`default_nettype none
module periph_event_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Bench command and events out
  input wire logic [23:0] fire,
  output logic [23:0] evt
);
  // Sources raise conditions when told, blind to any enable
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      evt <= 24'h00_0000;
    end else begin
      evt <= fire;
    end
  end
endmodule : periph_event_model
`default_nettype wire

/* File: tb/peripheral_interrupt_flags_tb.sv */
// Self-checking bench for the peripheral interrupt flag block
`timescale 1ns/10ps
`default_nettype none
module peripheral_interrupt_flags_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, periph_irq_req, core_irq_req, irq;
  logic [23:0] fire = 24'h00_0000;
  logic [23:0] evt;
  logic [7:0] ofs [4] = '{irq_flags_pkg::OFS_ENABLE_3,
    irq_flags_pkg::OFS_REQUEST_1, irq_flags_pkg::OFS_REQUEST_2,
    irq_flags_pkg::OFS_REQUEST_3};
  logic [7:0] msk [4] = '{8'h7F, 8'hCF, 8'hEF, 8'h7F};
  int error_cnt = 0;
  int check_count = 0;

  // Clock
  always #2 sys_clk = ~sys_clk;

  // Event sources and the block
  periph_event_model src (.sys_clk(sys_clk), .reset_n(reset_n),
    .fire(fire), .evt(evt));
  peripheral_interrupt_flags dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .t1_gate_evt(evt[7]), .converter_evt(evt[6]),
    .serial_rx_level(evt[5]), .serial_tx_level(evt[4]),
    .sync_serial_evt(evt[3]), .capture1_evt(evt[2]),
    .t2_match_evt(evt[1]), .t1_overflow_evt(evt[0]),
    .osc_fail_evt(evt[15]), .comparator2_evt(evt[14]),
    .comparator1_evt(evt[13]), .bus_collision_evt(evt[11]),
    .t6_match_evt(evt[10]), .t4_match_evt(evt[9]), .capture2_evt(evt[8]),
    .osc_gen_evt(evt[22]), .shutdown_evt(evt[21]),
    .zero_cross_evt(evt[20]), .logic_cell_evt(evt[19:16]),
    .periph_irq_req(periph_irq_req), .core_irq_req(core_irq_req),
    .irq(irq)
  );

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic flag(input logic got, input logic exp);
    chk(32'(got), 32'(exp));
  endtask : flag
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle
  // One bus access held until waitrequest is seen low
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h00_0000, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (n == 64) error_cnt++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(q, {24'h00_0000, e});
  endtask : rd
  // Fire sources for one cycle; bits 5 and 4 stay as levels
  task automatic pulse(input logic [23:0] m);
    @(posedge sys_clk);
    fire <= fire | m;
    @(posedge sys_clk);
    fire <= fire & 24'h00_0030;
    idle(2);
  endtask : pulse
  task automatic rst();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    idle(2);
    reset_n <= 1'b1;
  endtask : rst
  // Every location from 0x00 to 0x30, unmapped ones too, reads zero
  task automatic zeros();
    for (int a = 0; a <= 'h30; a += 4) rd(8'(a), 8'h00);
  endtask : zeros
  task automatic stop_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // Watchdog
  initial begin
    idle(20000);
    error_cnt++;
    stop_test();
  end

  // Test sequence
  initial begin
    rst();
    zeros();
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    // Writable and fixed bits of each bank
    for (int k = 0; k < 4; k++) begin
      wr(ofs[k], 8'hFF);
      rd(ofs[k], msk[k]);
      wr(ofs[k], 8'h00);
      rd(ofs[k], 8'h00);
    end
    // Every source sets its flag with all enables off
    pulse(24'h7F_EFFF);
    rd(irq_flags_pkg::OFS_REQUEST_1, 8'hFF);
    rd(irq_flags_pkg::OFS_REQUEST_2, 8'hEF);
    rd(irq_flags_pkg::OFS_REQUEST_3, 8'h7F);
    flag(periph_irq_req, 1'b0);
    wr(irq_flags_pkg::OFS_REQUEST_1, 8'h00);
    rd(irq_flags_pkg::OFS_REQUEST_1, 8'h30);
    @(posedge sys_clk);
    fire <= 24'h00_0000;
    idle(2);
    rd(irq_flags_pkg::OFS_REQUEST_1, 8'h00);
    wr(irq_flags_pkg::OFS_REQUEST_2, 8'h00);
    // Each third-bank source passes only through its own enable
    for (int i = 0; i < 7; i++) begin
      wr(irq_flags_pkg::OFS_CORE_CTRL, 8'hC0);
      wr(irq_flags_pkg::OFS_REQUEST_3, 8'h00);
      wr(irq_flags_pkg::OFS_ENABLE_3, 8'h7F ^ (8'h01 << i));
      pulse(24'h01_0000 << i);
      flag(periph_irq_req, 1'b0);
      wr(irq_flags_pkg::OFS_CORE_CTRL, 8'h80);
      wr(irq_flags_pkg::OFS_ENABLE_3, 8'h01 << i);
      idle(1);
      flag(periph_irq_req, 1'b0);
      wr(irq_flags_pkg::OFS_CORE_CTRL, 8'hC0);
      idle(1);
      flag(periph_irq_req, 1'b1);
      flag(core_irq_req, 1'b1);
    end
    wr(irq_flags_pkg::OFS_CORE_CTRL, 8'h40);
    idle(1);
    flag(periph_irq_req, 1'b1);
    flag(core_irq_req, 1'b0);
    // Status raised, masked and cleared
    wr(irq_flags_pkg::OFS_REQUEST_3, 8'h00);
    wr(irq_flags_pkg::OFS_IRQ_STATUS, 8'h07);
    rd(irq_flags_pkg::OFS_IRQ_STATUS, 8'h00);
    wr(irq_flags_pkg::OFS_IRQ_MASK, 8'h04);
    pulse(24'h01_0000);
    flag(irq, 1'b1);
    rd(irq_flags_pkg::OFS_IRQ_STATUS, 8'h04);
    wr(irq_flags_pkg::OFS_IRQ_MASK, 8'h00);
    idle(1);
    flag(irq, 1'b0);
    wr(irq_flags_pkg::OFS_IRQ_MASK, 8'h04);
    idle(1);
    flag(irq, 1'b1);
    wr(irq_flags_pkg::OFS_IRQ_STATUS, 8'h04);
    idle(1);
    flag(irq, 1'b0);
    rd(irq_flags_pkg::OFS_REQUEST_3, 8'h01);
    // First and second banks pass through their own enables
    avs_byteenable <= 4'hE;
    wr(irq_flags_pkg::OFS_ENABLE_2, 8'h08);
    avs_byteenable <= 4'hF;
    rd(irq_flags_pkg::OFS_ENABLE_2, 8'h00);
    wr(irq_flags_pkg::OFS_ENABLE_1, 8'h20);
    wr(irq_flags_pkg::OFS_ENABLE_2, 8'h08);
    pulse(24'h00_0820);
    rd(irq_flags_pkg::OFS_PENDING, 8'h03);
    wr(irq_flags_pkg::OFS_REQUEST_2, 8'h00);
    rd(irq_flags_pkg::OFS_PENDING, 8'h01);
    flag(periph_irq_req, 1'b1);
    @(posedge sys_clk);
    fire <= 24'h00_0000;
    idle(3);
    flag(periph_irq_req, 1'b0);
    // Reset in mid-run clears everything
    pulse(24'h7F_EFCF);
    wr(irq_flags_pkg::OFS_ENABLE_3, 8'h7F);
    rst();
    zeros();
    stop_test();
  end
endmodule : peripheral_interrupt_flags_tb

bind peripheral_interrupt_flags irq_flags_sva u_sva (
  .sys_clk(sys_clk), .reset_n(reset_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .serial_rx_level(serial_rx_level),
  .serial_tx_level(serial_tx_level), .periph_irq_req(periph_irq_req),
  .core_irq_req(core_irq_req), .irq(irq)
);
`default_nettype wire
